//--- hdl/display_power_pkg.sv
package display_power_pkg;

  // register offsets
  localparam logic [7:0] ADDR_PART_IDENTITY = 8'h00;
  localparam logic [7:0] ADDR_TEMPERATURE_READING = 8'h01;
  localparam logic [7:0] ADDR_MAIN_CONTROL = 8'h02;
  localparam logic [7:0] ADDR_RAIL_FAULT_MASK = 8'h03;
  localparam logic [7:0] ADDR_STORED_COMMON_LOWER_BOUND = 8'h21;
  localparam logic [7:0] ADDR_STORED_COMMON_UPPER_BOUND = 8'h22;
  localparam logic [7:0] ADDR_STORED_POSITIVE_RAIL_LEVEL = 8'h23;
  localparam logic [7:0] ADDR_STORED_GATE_ON_LEVEL = 8'h24;
  localparam logic [7:0] ADDR_STORED_GATE_OFF_LEVEL = 8'h25;
  localparam logic [7:0] ADDR_BURN_COMMAND = 8'h78;
  localparam logic [7:0] ADDR_RELOAD_COMMAND = 8'h79;
  localparam logic [7:0] ADDR_SOFT_RESTART_COMMAND = 8'h7A;
  localparam int NV_STORE_COUNT = 5;

  // main_control field positions
  localparam int CTRL_PARITY_ENABLE_BIT = 7;
  localparam int CTRL_START_BIT = 6;
  localparam int CTRL_NONVOLATILE_WRITE_COUNT_LSB = 3;
  localparam int CTRL_REVISION_LSB = 0;

  // rail_fault_mask field positions
  localparam int POSITIVE_RAIL_OVER_MASK_BIT = 7;
  localparam int POSITIVE_RAIL_UNDER_MASK_BIT = 6;
  localparam int NEGATIVE_RAIL_OVER_MASK_BIT = 5;
  localparam int NEGATIVE_RAIL_UNDER_MASK_BIT = 4;
  localparam int GATE_HIGH_OVER_MASK_BIT = 3;
  localparam int GATE_HIGH_UNDER_MASK_BIT = 2;
  localparam int GATE_LOW_OVER_MASK_BIT = 1;
  localparam int GATE_LOW_UNDER_MASK_BIT = 0;

  // reset values
  localparam logic [7:0] TEMPERATURE_RESET = 8'h00;
  localparam logic [7:0] RAIL_FAULT_MASK_RESET = 8'h00;
  localparam logic [7:0] NV_STORE_RESET = 8'h00;
  localparam logic PARITY_ENABLE_RESET = 1'b0;
  localparam logic START_RESET_STANDARD = 1'b0;
  localparam logic START_RESET_STANDALONE = 1'b1;
  localparam logic [2:0] NONVOLATILE_WRITE_COUNT_RESET = 3'h0;
  localparam logic [2:0] NONVOLATILE_WRITE_COUNT_MAX = 3'h6;

  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_ADDR_END, ST_ADDR_ACK, ST_REG, ST_REG_END, ST_REG_ACK,
    ST_WR, ST_WR_END, ST_WR_ACK, ST_RD, ST_RD_ACK, ST_RD_LOAD
  } slave_state_t;

endpackage : display_power_pkg

//--- hdl/i2c_event_if.sv
`timescale 1ns/1ps
interface i2c_event_if;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic sda_level;
  modport producer (output scl_rise, output scl_fall, output start_det, output stop_det, output sda_level);
  modport consumer (input scl_rise, input scl_fall, input start_det, input stop_det, input sda_level);
endinterface : i2c_event_if

//--- hdl/i2c_pin_conditioner.sv
`timescale 1ns/1ps
module i2c_pin_conditioner
  import display_power_pkg::*;
(
  input wire logic core_clk_i,     // system clock
  input wire logic resetn_i,       // async reset, active low
  input wire logic scl_i,          // serial clock pin
  input wire logic sda_i,          // serial data pin level
  i2c_event_if.producer ev         // conditioned bus events
);

  typedef struct packed {
    logic [2:0] scl_s;
    logic [2:0] sda_s;
    logic scl_f;
    logic sda_f;
    logic rise;
    logic fall;
    logic start;
    logic stop;
  } cond_t;

  localparam cond_t COND_RESET = '{scl_s: 3'h7, sda_s: 3'h7, scl_f: 1'b1, sda_f: 1'b1,
                                   rise: 1'b0, fall: 1'b0, start: 1'b0, stop: 1'b0};

  cond_t r;
  cond_t n;

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    n = r;
    // stage 0 feeds stage 1 only; the filter looks at stages 1 and 2
    n.scl_s = {r.scl_s[1:0], scl_i};
    n.sda_s = {r.sda_s[1:0], sda_i};
    if (r.scl_s[1] == r.scl_s[2])
    begin
      n.scl_f = r.scl_s[2];
    end
    if (r.sda_s[1] == r.sda_s[2])
    begin
      n.sda_f = r.sda_s[2];
    end
    n.rise = n.scl_f & ~r.scl_f;
    n.fall = ~n.scl_f & r.scl_f;
    // data edges only count as framing while the clock stays high
    n.start = r.sda_f & ~n.sda_f & r.scl_f & n.scl_f;
    n.stop = ~r.sda_f & n.sda_f & r.scl_f & n.scl_f;
  end

  always_ff @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      r <= COND_RESET;
    end
    else
    begin
      r <= n;
    end
  end

  assign ev.scl_rise = r.rise;
  assign ev.scl_fall = r.fall;
  assign ev.start_det = r.start;
  assign ev.stop_det = r.stop;
  assign ev.sda_level = r.sda_f;

endmodule : i2c_pin_conditioner

//--- hdl/display_power_ctrl_regs.sv
//
// Overview of operation
// R1 - parity enable bit gates write parity checking
// R2 - writing start one launches power-up ordering
// R3 - start resets zero, stand-alone variant one
// R4 - write count field saturates at six
// R5 - control low bits read fixed revision
// R6 - lowest address returns six-bit part identifier
// R7 - temperature reading read-only, zero after reset
// R8 - positive rail over/under masks block alert
// R9 - negative rail over/under masks block alert
// R10 - gate-high over/under masks block alert
// R11 - gate-low masks block alert; masks reset zero
// R12 - host fixes parity through payload byte
// R13 - alert low while unmasked rail fault present
`timescale 1ns/1ps
module display_power_ctrl_regs
  import display_power_pkg::*;
#(
  parameter logic [6:0] SLAVE_ADDR = 7'h30,          // bus address of this device
  parameter logic [5:0] PART_ID = 6'h15,             // arbitrary value
  parameter logic [2:0] REVISION_ID = 3'h5,          // arbitrary value
  parameter bit STANDALONE_VARIANT = 1'b0            // 1 selects the self-starting variant
)
(
  input wire logic core_clk_i,                // system clock
  input wire logic resetn_i,                  // async reset, active low
  input wire logic scl_i,                     // serial clock pin
  input wire logic sda_i,                     // serial data pin level
  output logic sda_o,                         // serial data drive value, always low
  output logic sda_oe_o,                      // serial data pull-down enable
  input wire logic [7:0] rail_fault_i,        // rail fault flags, mask bit order
  input wire logic [7:0] temp_code_i,         // digitized reference resistor pin voltage
  input wire logic temp_valid_i,              // new temperature code strobe
  input wire logic nv_write_done_i,           // one nonvolatile write finished
  input wire logic fault_alert_pin_n_i,       // alert pin level, not used
  output logic fault_alert_pin_n_o,           // alert drive value, always low
  output logic fault_alert_pin_n_oe_o,        // alert pull-down enable
  output logic power_start_o,                 // start bit level
  output logic start_pulse_o,                 // start bit written with one
  output logic burn_cmd_o,                    // burn command pulse
  output logic reload_cmd_o,                  // reload command pulse
  output logic restart_cmd_o,                 // soft restart command pulse
  output logic [7:0] cmd_payload_o,           // payload of last command
  output logic parity_error_o,                // write refused on parity
  output logic [NV_STORE_COUNT*8-1:0] nv_store_o  // stored settings, 0x21 in low byte
);

  if (SLAVE_ADDR == 7'h00)
  begin : g_addr_check
    $error("general call address cannot be the slave address");
  end

  typedef struct packed {
    slave_state_t st;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic [7:0] addr_byte;
    logic [7:0] reg_byte;
    logic [7:0] ptr;
    logic ack_ok;
    logic sda_oe;
    logic par_en;
    logic start;
    logic [2:0] nv_cnt;
    logic [7:0] temp;
    logic [7:0] mask;
    logic [NV_STORE_COUNT-1:0][7:0] nv_store;
    logic alert;
    logic start_pulse;
    logic burn;
    logic reload;
    logic restart;
    logic [7:0] payload;
    logic par_err;
  } regs_t;

  localparam regs_t REGS_RESET = '{
    st: ST_IDLE, cnt: 4'h0, sh: 8'h00, addr_byte: 8'h00, reg_byte: 8'h00, ptr: 8'h00,
    ack_ok: 1'b0, sda_oe: 1'b0, par_en: PARITY_ENABLE_RESET,
    start: STANDALONE_VARIANT ? START_RESET_STANDALONE : START_RESET_STANDARD,  // see R3
    nv_cnt: NONVOLATILE_WRITE_COUNT_RESET, temp: TEMPERATURE_RESET, mask: RAIL_FAULT_MASK_RESET,  // see R11
    nv_store: {NV_STORE_COUNT{NV_STORE_RESET}}, alert: 1'b0, start_pulse: 1'b0,
    burn: 1'b0, reload: 1'b0, restart: 1'b0, payload: 8'h00, par_err: 1'b0};

  i2c_event_if ev ();

  i2c_pin_conditioner u_cond (
    .core_clk_i (core_clk_i),
    .resetn_i (resetn_i),
    .scl_i (scl_i),
    .sda_i (sda_i),
    .ev (ev)
  );

  regs_t r;
  regs_t n;
  logic [7:0] rx_byte;
  logic [7:0] rd_byte;
  logic par_ok;

  ////////////////////////////////////////////////////////////////////////////
  // read map; write-only and unmapped offsets read zero
  always_comb
  begin
    rd_byte = 8'h00;
    unique case (r.ptr)
      ADDR_PART_IDENTITY: rd_byte = {2'b00, PART_ID};  // see R6
      ADDR_TEMPERATURE_READING: rd_byte = r.temp;  // see R7
      ADDR_MAIN_CONTROL: rd_byte = {r.par_en, r.start, r.nv_cnt, REVISION_ID};  // see R4, see R5
      ADDR_RAIL_FAULT_MASK: rd_byte = r.mask;
      default:
      begin
        for (int i = 0; i < NV_STORE_COUNT; i++)
        begin
          if (r.ptr == 8'(ADDR_STORED_COMMON_LOWER_BOUND + i))
          begin
            rd_byte = r.nv_store[i];
          end
        end
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    n = r;
    n.start_pulse = 1'b0;
    n.burn = 1'b0;
    n.reload = 1'b0;
    n.restart = 1'b0;
    n.par_err = 1'b0;
    rx_byte = {r.sh[6:0], ev.sda_level};
    // parity covers address, register and payload bytes, so the host trims the payload
    par_ok = !r.par_en || !(^{r.addr_byte, r.reg_byte, rx_byte});  // see R1, see R12
    n.alert = |(rail_fault_i & ~r.mask);  // see R8, see R9, see R10, see R11, see R13
    if (temp_valid_i)
    begin
      n.temp = temp_code_i;  // see R7
    end
    if (nv_write_done_i && (r.nv_cnt < NONVOLATILE_WRITE_COUNT_MAX))
    begin
      n.nv_cnt = r.nv_cnt + 3'h1;  // see R4
    end
    if (ev.start_det)
    begin
      n.st = ST_ADDR;
      n.cnt = 4'h0;
      n.sda_oe = 1'b0;
    end
    else if (ev.stop_det)
    begin
      n.st = ST_IDLE;
      n.sda_oe = 1'b0;
    end
    else
    begin
      unique case (r.st)
        ST_IDLE: ;
        ST_ADDR, ST_REG, ST_WR:
        begin
          if (ev.scl_rise)
          begin
            n.sh = rx_byte;
            n.cnt = r.cnt + 4'h1;
            if (r.cnt == 4'h7)
            begin
              if (r.st == ST_ADDR)
              begin
                n.addr_byte = rx_byte;
                n.ack_ok = (rx_byte[7:1] == SLAVE_ADDR);
                n.st = ST_ADDR_END;
              end
              else if (r.st == ST_REG)
              begin
                n.reg_byte = rx_byte;
                n.ptr = rx_byte;
                n.st = ST_REG_END;
              end
              else
              begin
                n.st = ST_WR_END;
                n.ack_ok = par_ok;
                n.par_err = !par_ok;  // see R1
                if (par_ok)
                begin
                  unique case (r.ptr)
                    ADDR_MAIN_CONTROL:
                    begin
                      n.par_en = rx_byte[CTRL_PARITY_ENABLE_BIT];
                      n.start = rx_byte[CTRL_START_BIT];
                      n.start_pulse = rx_byte[CTRL_START_BIT];  // see R2
                    end
                    ADDR_RAIL_FAULT_MASK: n.mask = rx_byte;
                    ADDR_BURN_COMMAND:
                    begin
                      n.burn = 1'b1;
                      n.payload = rx_byte;
                    end
                    ADDR_RELOAD_COMMAND:
                    begin
                      n.reload = 1'b1;
                      n.payload = rx_byte;
                    end
                    ADDR_SOFT_RESTART_COMMAND:
                    begin
                      n.restart = 1'b1;
                      n.payload = rx_byte;
                    end
                    default:
                    begin
                      for (int i = 0; i < NV_STORE_COUNT; i++)
                      begin
                        if (r.ptr == 8'(ADDR_STORED_COMMON_LOWER_BOUND + i))
                        begin
                          n.nv_store[i] = rx_byte;
                        end
                      end
                    end
                  endcase
                end
              end
            end
          end
        end
        ST_ADDR_END, ST_WR_END:
        begin
          if (ev.scl_fall)
          begin
            n.sda_oe = r.ack_ok;
            // a refused byte is not acknowledged and the device drops off the bus
            n.st = !r.ack_ok ? ST_IDLE : ((r.st == ST_ADDR_END) ? ST_ADDR_ACK : ST_WR_ACK);
          end
        end
        ST_REG_END:
        begin
          if (ev.scl_fall)
          begin
            n.sda_oe = 1'b1;
            n.st = ST_REG_ACK;
          end
        end
        ST_ADDR_ACK, ST_RD_LOAD:
        begin
          if (ev.scl_fall)
          begin
            n.cnt = 4'h0;
            n.sda_oe = 1'b0;
            n.st = ST_REG;
            if (r.st == ST_RD_LOAD || r.addr_byte[0])
            begin
              n.sh = {rd_byte[6:0], 1'b0};
              n.sda_oe = ~rd_byte[7];
              n.cnt = 4'h1;
              n.st = ST_RD;
            end
          end
        end
        ST_REG_ACK, ST_WR_ACK:
        begin
          if (ev.scl_fall)
          begin
            n.sda_oe = 1'b0;
            n.cnt = 4'h0;
            n.st = ST_WR;
            if (r.st == ST_WR_ACK)
            begin
              n.ptr = r.ptr + 8'h01;
            end
          end
        end
        ST_RD:
        begin
          if (ev.scl_fall)
          begin
            if (r.cnt == 4'h8)
            begin
              n.sda_oe = 1'b0;
              n.st = ST_RD_ACK;
            end
            else
            begin
              n.sda_oe = ~r.sh[7];
              n.sh = {r.sh[6:0], 1'b0};
              n.cnt = r.cnt + 4'h1;
            end
          end
        end
        ST_RD_ACK:
        begin
          if (ev.scl_rise)
          begin
            n.st = ev.sda_level ? ST_IDLE : ST_RD_LOAD;
            n.ptr = ev.sda_level ? r.ptr : r.ptr + 8'h01;
          end
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      r <= REGS_RESET;
    end
    else
    begin
      r <= n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign sda_o = 1'b0;
  assign sda_oe_o = r.sda_oe;
  assign fault_alert_pin_n_o = 1'b0;
  assign fault_alert_pin_n_oe_o = r.alert;
  assign power_start_o = r.start;
  assign start_pulse_o = r.start_pulse;
  assign burn_cmd_o = r.burn;
  assign reload_cmd_o = r.reload;
  assign restart_cmd_o = r.restart;
  assign cmd_payload_o = r.payload;
  assign parity_error_o = r.par_err;
  assign nv_store_o = r.nv_store;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  logic after_rst_r;

  always_ff @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      after_rst_r <= 1'b0;
    end
    else
    begin
      after_rst_r <= 1'b1;
    end
  end

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!resetn_i);

  sequence s_data_done;
    r.st == ST_WR && ev.scl_rise && !ev.start_det && !ev.stop_det && r.cnt == 4'h7;
  endsequence

  sequence s_good_start_write;
    s_data_done ##0 (par_ok && r.ptr == ADDR_MAIN_CONTROL && rx_byte[CTRL_START_BIT]);
  endsequence

  parity_refuse_a: assert property (s_data_done ##0 (r.par_en && ^{r.addr_byte, r.reg_byte, rx_byte})
    |=> r.par_err && !r.ack_ok ##1 !r.par_err) else $error("bad parity write not refused");  // see R1
  parity_off_a: assert property (s_data_done ##0 !r.par_en |=> !r.par_err && r.ack_ok)
    else $error("write refused with parity off");  // see R1
  start_launch_a: assert property (s_good_start_write |=> start_pulse_o && power_start_o ##1 !start_pulse_o)
    else $error("start write did not launch sequence");  // see R2
  start_reset_a: assert property (!after_rst_r |-> power_start_o == STANDALONE_VARIANT)
    else $error("start bit reset value wrong");  // see R3
  nonvolatile_write_count_a: assert property (nv_write_done_i && r.nv_cnt < NONVOLATILE_WRITE_COUNT_MAX |=> r.nv_cnt == $past(r.nv_cnt) + 3'h1)
    else $error("write count did not step");  // see R4
  nv_saturate_a: assert property (r.nv_cnt == NONVOLATILE_WRITE_COUNT_MAX |=> r.nv_cnt == NONVOLATILE_WRITE_COUNT_MAX)
    else $error("write count left its ceiling");  // see R4
  revision_read_a: assert property (r.ptr == ADDR_MAIN_CONTROL |-> rd_byte[2:0] == REVISION_ID)
    else $error("revision field wrong");  // see R5
  part_read_a: assert property (r.ptr == ADDR_PART_IDENTITY |-> rd_byte == {2'b00, PART_ID})
    else $error("part identifier wrong");  // see R6
  temp_capture_a: assert property (temp_valid_i |=> r.temp == $past(temp_code_i))
    else $error("temperature not captured");  // see R7
  pos_rail_mask_a: assert property (|(rail_fault_i[7:6] & ~r.mask[7:6]) |=> fault_alert_pin_n_oe_o)
    else $error("positive rail fault not alerted");  // see R8
  neg_rail_mask_a: assert property (|(rail_fault_i[5:4] & ~r.mask[5:4]) |=> fault_alert_pin_n_oe_o)
    else $error("negative rail fault not alerted");  // see R9
  gate_high_mask_a: assert property (|(rail_fault_i[3:2] & ~r.mask[3:2]) |=> fault_alert_pin_n_oe_o)
    else $error("gate-high fault not alerted");  // see R10
  gate_low_mask_a: assert property (|(rail_fault_i[1:0] & ~r.mask[1:0]) |=> fault_alert_pin_n_oe_o)
    else $error("gate-low fault not alerted");  // see R11
  alert_release_a: assert property (!(|(rail_fault_i & ~r.mask)) |=> !fault_alert_pin_n_oe_o)
    else $error("alert held with no unmasked fault");  // see R13

endmodule : display_power_ctrl_regs

//--- tb/i2c_host_model.sv
`timescale 1ns/1ps
module i2c_host_model #(
  parameter logic [6:0] DEV_ADDR = 7'h30  // bus address of the device
)
(
  input wire logic core_clk_i,  // system clock
  input wire logic sda_i,       // resolved data line
  output logic scl_o,           // serial clock, idles high
  output logic sda_low_o        // high pulls the data line low
);
  // quarter bit in core cycles; keeps each data change well clear of a clock edge
  localparam int Q = 8;

  initial
  begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end

  task automatic w(input int n);
    repeat (n) @(posedge core_clk_i);
  endtask : w

  task automatic bit_out(input logic b);
    sda_low_o <= ~b;
    w(Q);
    scl_o <= 1'b1;
    w(2 * Q);
    scl_o <= 1'b0;
    w(Q);
  endtask : bit_out

  task automatic bit_in(output logic b);
    sda_low_o <= 1'b0;
    w(Q);
    scl_o <= 1'b1;
    w(Q);
    b = sda_i;
    w(Q);
    scl_o <= 1'b0;
    w(Q);
  endtask : bit_in

  // also serves as repeated start when the clock is low
  task automatic cond_start();
    sda_low_o <= 1'b0;
    w(Q);
    scl_o <= 1'b1;
    w(Q);
    sda_low_o <= 1'b1;
    w(Q);
    scl_o <= 1'b0;
    w(Q);
  endtask : cond_start

  task automatic cond_stop();
    sda_low_o <= 1'b1;
    w(Q);
    scl_o <= 1'b1;
    w(Q);
    sda_low_o <= 1'b0;
    w(Q);
  endtask : cond_stop

  task automatic byte_out(input logic [7:0] d, output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--)
      bit_out(d[i]);
    bit_in(b);
    ack = ~b;
  endtask : byte_out

  task automatic byte_in(output logic [7:0] d, input logic last);
    logic b;
    for (int i = 7; i >= 0; i--)
    begin
      bit_in(b);
      d[i] = b;
    end
    bit_out(last);
  endtask : byte_in

  // parity is mended in the payload only, the command byte stays as it is
  function automatic logic [7:0] fix_par(input logic [7:0] r, input logic [7:0] d);
    return {d[7:1], d[0] ^ (^{DEV_ADDR, 1'b0, r, d})};
  endfunction : fix_par

  task automatic wr(input logic [7:0] r, input logic [7:0] d, output logic ack);
    logic a0;
    logic a1;
    logic a2;
    cond_start();
    byte_out({DEV_ADDR, 1'b0}, a0);
    byte_out(r, a1);
    byte_out(d, a2);
    cond_stop();
    ack = a0 & a1 & a2;
  endtask : wr

  task automatic rd(input logic [7:0] r, output logic [7:0] d);
    logic a;
    cond_start();
    byte_out({DEV_ADDR, 1'b0}, a);
    byte_out(r, a);
    cond_start();
    byte_out({DEV_ADDR, 1'b1}, a);
    byte_in(d, 1'b1);
    cond_stop();
  endtask : rd
endmodule : i2c_host_model

//--- tb/testbench.sv
`timescale 1ns/1ps
module testbench;
  import display_power_pkg::*;

  // arbitrary identification values
  localparam logic [5:0] P_ID = 6'h2B;
  localparam logic [2:0] P_REV = 3'h3;

  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic scl, host_low, sda_d, sda_oe, sda_oe2, alert_drv, alert_oe;
  logic power_start, power_start2, start_pulse, burn, reload, restart, par_err;
  logic [7:0] rail_fault = 8'h00;
  logic [7:0] temp_code = 8'h00;
  logic temp_valid = 1'b0;
  logic nv_done = 1'b0;
  logic [7:0] payload;
  logic [39:0] nv_store;
  logic [7:0] n_start, n_burn, n_reload, n_restart, n_par;
  int n_mismatch = 0;
  int comparisons = 0;
  wire logic sda = ~host_low & (sda_oe ? sda_d : 1'b1) & ~sda_oe2;
  wire logic alert_pin = alert_oe ? alert_drv : 1'b1;

  initial
    forever #4 core_clk = ~core_clk;

  i2c_host_model #(.DEV_ADDR(7'h30)) host (.core_clk_i(core_clk), .sda_i(sda), .scl_o(scl), .sda_low_o(host_low));

  display_power_ctrl_regs #(.SLAVE_ADDR(7'h30), .PART_ID(P_ID), .REVISION_ID(P_REV), .STANDALONE_VARIANT(1'b0)) dut (
    .core_clk_i(core_clk), .resetn_i(resetn), .scl_i(scl), .sda_i(sda), .sda_o(sda_d), .sda_oe_o(sda_oe),
    .rail_fault_i(rail_fault), .temp_code_i(temp_code), .temp_valid_i(temp_valid), .nv_write_done_i(nv_done),
    .fault_alert_pin_n_i(alert_pin), .fault_alert_pin_n_o(alert_drv), .fault_alert_pin_n_oe_o(alert_oe),
    .power_start_o(power_start), .start_pulse_o(start_pulse), .burn_cmd_o(burn), .reload_cmd_o(reload),
    .restart_cmd_o(restart), .cmd_payload_o(payload), .parity_error_o(par_err), .nv_store_o(nv_store));

  // self-starting variant on another address, so it never answers on the shared bus
  display_power_ctrl_regs #(.SLAVE_ADDR(7'h31), .PART_ID(P_ID), .REVISION_ID(P_REV), .STANDALONE_VARIANT(1'b1))
  dut_standalone (
    .core_clk_i(core_clk), .resetn_i(resetn), .scl_i(scl), .sda_i(sda), .sda_o(), .sda_oe_o(sda_oe2),
    .rail_fault_i(rail_fault), .temp_code_i(temp_code), .temp_valid_i(temp_valid), .nv_write_done_i(nv_done),
    .fault_alert_pin_n_i(alert_pin), .fault_alert_pin_n_o(), .fault_alert_pin_n_oe_o(),
    .power_start_o(power_start2), .start_pulse_o(), .burn_cmd_o(), .reload_cmd_o(), .restart_cmd_o(),
    .cmd_payload_o(), .parity_error_o(), .nv_store_o());

  always @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      {n_start, n_burn, n_reload, n_restart, n_par} <= 40'h0;
    else
    begin
      n_start <= n_start + {7'h0, start_pulse};
      n_burn <= n_burn + {7'h0, burn};
      n_reload <= n_reload + {7'h0, reload};
      n_restart <= n_restart + {7'h0, restart};
      n_par <= n_par + {7'h0, par_err};
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] r, input logic [7:0] d, input logic exp_ack);
    logic a;
    host.wr(r, d, a);
    chk({7'h0, a}, {7'h0, exp_ack});
  endtask : wr

  task automatic rdc(input logic [7:0] r, input logic [7:0] exp);
    logic [7:0] d;
    host.rd(r, d);
    chk(d, exp);
  endtask : rdc

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rdc(ADDR_PART_IDENTITY, {2'b00, P_ID});
    rdc(ADDR_TEMPERATURE_READING, 8'h00);
    rdc(ADDR_MAIN_CONTROL, {5'h00, P_REV});
    rdc(ADDR_RAIL_FAULT_MASK, 8'h00);
    chk({7'h0, power_start}, 8'h00);
    chk({7'h0, power_start2}, 8'h01);
  endtask : t_reset

  task automatic t_readonly();
    wr(ADDR_PART_IDENTITY, 8'hFF, 1'b1);
    wr(ADDR_TEMPERATURE_READING, 8'hFF, 1'b1);
    wr(ADDR_MAIN_CONTROL, 8'h3F, 1'b1);
    rdc(ADDR_PART_IDENTITY, {2'b00, P_ID});
    rdc(ADDR_TEMPERATURE_READING, 8'h00);
    rdc(ADDR_MAIN_CONTROL, {5'h00, P_REV});
  endtask : t_readonly

  task automatic t_start();
    wr(ADDR_MAIN_CONTROL, 8'h40, 1'b1);
    chk(n_start, 8'h01);
    chk({7'h0, power_start}, 8'h01);
    rdc(ADDR_MAIN_CONTROL, {5'h08, P_REV});
    wr(ADDR_MAIN_CONTROL, 8'h00, 1'b1);
    chk(n_start, 8'h01);
    chk({7'h0, power_start}, 8'h00);
  endtask : t_start

  task automatic t_count();
    for (int k = 0; k < 2; k++)
    begin
      repeat (k ? 5 : 3)
      begin
        @(posedge core_clk);
        nv_done <= 1'b1;
        @(posedge core_clk);
        nv_done <= 1'b0;
      end
      rdc(ADDR_MAIN_CONTROL, {2'b00, (k ? 3'h6 : 3'h3), P_REV});
    end
  endtask : t_count

  task automatic t_temp();
    @(posedge core_clk);
    temp_code <= 8'hA5;
    temp_valid <= 1'b1;
    @(posedge core_clk);
    temp_valid <= 1'b0;
    temp_code <= 8'h3C;
    rdc(ADDR_TEMPERATURE_READING, 8'hA5);
  endtask : t_temp

  task automatic t_mask();
    logic [7:0] m;
    for (int k = 0; k < 2; k++)
    begin
      m = k ? 8'h55 : 8'hAA;
      wr(ADDR_RAIL_FAULT_MASK, m, 1'b1);
      rdc(ADDR_RAIL_FAULT_MASK, m);
      for (int i = 0; i < 8; i++)
      begin
        @(posedge core_clk);
        rail_fault <= 8'h01 << i;
        repeat (3) @(posedge core_clk);
        chk({7'h0, alert_pin}, {7'h0, m[i]});
      end
      @(posedge core_clk);
      rail_fault <= 8'h00;
      repeat (3) @(posedge core_clk);
      chk({7'h0, alert_pin}, 8'h01);
    end
  endtask : t_mask

  task automatic t_parity();
    logic [7:0] d;
    wr(ADDR_RAIL_FAULT_MASK, 8'h01, 1'b1);
    rdc(ADDR_RAIL_FAULT_MASK, 8'h01);
    wr(ADDR_MAIN_CONTROL, 8'h80, 1'b1);
    wr(ADDR_RAIL_FAULT_MASK, 8'h07, 1'b0);
    chk(n_par, 8'h01);
    rdc(ADDR_RAIL_FAULT_MASK, 8'h01);
    wr(ADDR_RAIL_FAULT_MASK, 8'h03, 1'b1);
    rdc(ADDR_RAIL_FAULT_MASK, 8'h03);
    for (int k = 0; k < 3; k++)
    begin
      d = host.fix_par(ADDR_BURN_COMMAND + 8'(k), 8'h5A);
      wr(ADDR_BURN_COMMAND + 8'(k), d, 1'b1);
      chk(payload, d);
    end
    chk(n_burn, 8'h01);
    chk(n_reload, 8'h01);
    chk(n_restart, 8'h01);
    wr(ADDR_MAIN_CONTROL, 8'h01, 1'b1);
    rdc(ADDR_MAIN_CONTROL, {2'b00, 3'h6, P_REV});
  endtask : t_parity

  // stored settings: write, read back, and watch the parallel copy; the burn command offset reads zero
  task automatic t_store();
    for (int k = 0; k < NV_STORE_COUNT; k++)
    begin
      wr(ADDR_STORED_COMMON_LOWER_BOUND + 8'(k), 8'h91 + 8'(k), 1'b1);
      rdc(ADDR_STORED_COMMON_LOWER_BOUND + 8'(k), 8'h91 + 8'(k));
      chk(nv_store[k*8 +: 8], 8'h91 + 8'(k));
    end
    rdc(ADDR_BURN_COMMAND, 8'h00);
    chk(n_burn, 8'h00);
  endtask : t_store

  ////////////////////////////////////////////////////////////////////////////////
  task automatic results();
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : results

  initial
  begin
    repeat (16) @(posedge core_clk);
    resetn <= 1'b1;
    repeat (8) @(posedge core_clk);
    t_reset();
    t_readonly();
    t_start();
    t_count();
    t_temp();
    t_store();
    t_mask();
    t_parity();
    results();
  end

  // the sequence needs about 40k cycles; 80k means a hung bus
  initial
  begin
    repeat (80000) @(posedge core_clk);
    n_mismatch++;
    results();
  end
endmodule : testbench
